// File: core/gpio_pkg.sv
package gpio_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int PORT_W     = 8;
  localparam int BYTE_SHIFT = 2;
  localparam int IDX_W      = ADDR_W - BYTE_SHIFT;
  localparam int CTL_W      = 4;
  localparam int CTL_LSB    = 4;

  // ---------------------------------------------------------------
  // Register indices, byte address is index times four
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA     = 10'h078;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA     = 10'h079;
  localparam logic [IDX_W-1:0] IDX_XCVR_CONTROL    = 10'h07A;
  localparam logic [IDX_W-1:0] IDX_PORT_A_LINE_DIR = 10'h098;
  localparam logic [IDX_W-1:0] IDX_PORT_B_LINE_DIR = 10'h099;
  localparam logic [IDX_W-1:0] IDX_XCVR_CTL_DIR    = 10'h09A;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_A_XCVR_DIR  = 7;
  localparam int BIT_A_XCVR_EN_N = 6;
  localparam int BIT_B_XCVR_DIR  = 5;
  localparam int BIT_B_XCVR_EN_N = 4;

  localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
  localparam logic [CTL_W-1:0]  CTL_RESET  = 4'h0;
  localparam logic [CTL_LSB-1:0] CTL_UNUSED = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Transceiver control bits, msb first as in bits 7 down to 4
  typedef struct packed {
    logic port_a_xcvr_dir;
    logic port_a_xcvr_enable_n;
    logic port_b_xcvr_dir;
    logic port_b_xcvr_enable_n;
  } xcvr_ctl_s;

  // Drive enables of the transceiver control bits, same order
  typedef struct packed {
    logic port_a_xcvr_dir_ctl_oe;
    logic port_a_xcvr_en_ctl_oe;
    logic port_b_xcvr_dir_ctl_oe;
    logic port_b_xcvr_en_ctl_oe;
  } xcvr_ctl_oe_s;

endpackage : gpio_pkg

// File: core/dual_port_buffered_gpio.sv
`timescale 1ns/1ps

module dual_port_buffered_gpio (
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [gpio_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [gpio_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [gpio_pkg::ADDR_W-1:0]   s_axi_araddr,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [gpio_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  input  wire logic [gpio_pkg::PORT_W-1:0]   port_a_line_in,
  output logic [gpio_pkg::PORT_W-1:0]        port_a_line_out,
  output logic [gpio_pkg::PORT_W-1:0]        port_a_line_oe,
  input  wire logic [gpio_pkg::PORT_W-1:0]   port_b_line_in,
  output logic [gpio_pkg::PORT_W-1:0]        port_b_line_out,
  output logic [gpio_pkg::PORT_W-1:0]        port_b_line_oe,
  output gpio_pkg::xcvr_ctl_s                xcvr_ctl,
  output gpio_pkg::xcvr_ctl_oe_s             xcvr_ctl_oe
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [gpio_pkg::PORT_W-1:0] port_a_data;
  logic [gpio_pkg::PORT_W-1:0] port_b_data;
  logic [gpio_pkg::PORT_W-1:0] port_a_line_dirs;
  logic [gpio_pkg::PORT_W-1:0] port_b_line_dirs;
  logic [gpio_pkg::PORT_W-1:0] port_a_meta;
  logic [gpio_pkg::PORT_W-1:0] port_b_meta;
  logic [gpio_pkg::PORT_W-1:0] port_a_sync;
  logic [gpio_pkg::PORT_W-1:0] port_b_sync;

  logic                        aw_hold;
  logic [gpio_pkg::IDX_W-1:0]  aw_idx;
  logic                        w_hold;
  logic [gpio_pkg::PORT_W-1:0] w_data_q;
  logic                        w_lane0;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire do_write = aw_hold && w_hold && !s_axi_bvalid;

  wire wr_map_a_data = (aw_idx == gpio_pkg::IDX_PORT_A_DATA);
  wire wr_map_b_data = (aw_idx == gpio_pkg::IDX_PORT_B_DATA);
  wire wr_map_ctl    = (aw_idx == gpio_pkg::IDX_XCVR_CONTROL);
  wire wr_map_a_dir  = (aw_idx == gpio_pkg::IDX_PORT_A_LINE_DIR);
  wire wr_map_b_dir  = (aw_idx == gpio_pkg::IDX_PORT_B_LINE_DIR);
  wire wr_map_cdir   = (aw_idx == gpio_pkg::IDX_XCVR_CTL_DIR);
  wire wr_mapped     = wr_map_a_data || wr_map_b_data || wr_map_ctl ||
                       wr_map_a_dir || wr_map_b_dir || wr_map_cdir;

  wire wr_en          = do_write && w_lane0;
  wire wr_hit_a_data  = wr_en && wr_map_a_data;
  wire wr_hit_b_data  = wr_en && wr_map_b_data;
  wire wr_hit_ctl     = wr_en && wr_map_ctl;
  wire wr_hit_a_dir   = wr_en && wr_map_a_dir;
  wire wr_hit_b_dir   = wr_en && wr_map_b_dir;
  wire wr_hit_cdir    = wr_en && wr_map_cdir;

  // Only bits 7 to 4 carry meaning in the control pair
  wire gpio_pkg::xcvr_ctl_s    wr_ctl_bits  = gpio_pkg::xcvr_ctl_s'(w_data_q[gpio_pkg::PORT_W-1:gpio_pkg::CTL_LSB]);
  wire gpio_pkg::xcvr_ctl_oe_s wr_cdir_bits = gpio_pkg::xcvr_ctl_oe_s'(w_data_q[gpio_pkg::PORT_W-1:gpio_pkg::CTL_LSB]);

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  wire [gpio_pkg::IDX_W-1:0] rd_idx = s_axi_araddr[gpio_pkg::ADDR_W-1:gpio_pkg::BYTE_SHIFT];

  wire rd_map_a_data = (rd_idx == gpio_pkg::IDX_PORT_A_DATA);
  wire rd_map_b_data = (rd_idx == gpio_pkg::IDX_PORT_B_DATA);
  wire rd_map_ctl    = (rd_idx == gpio_pkg::IDX_XCVR_CONTROL);
  wire rd_map_a_dir  = (rd_idx == gpio_pkg::IDX_PORT_A_LINE_DIR);
  wire rd_map_b_dir  = (rd_idx == gpio_pkg::IDX_PORT_B_LINE_DIR);
  wire rd_map_cdir   = (rd_idx == gpio_pkg::IDX_XCVR_CTL_DIR);
  wire rd_mapped     = rd_map_a_data || rd_map_b_data || rd_map_ctl ||
                       rd_map_a_dir || rd_map_b_dir || rd_map_cdir;

  // Output lines read their latch, input lines read the synchronised pin
  wire [gpio_pkg::PORT_W-1:0] port_a_view = (port_a_data & port_a_line_dirs) |
                                            (port_a_sync & ~port_a_line_dirs);
  wire [gpio_pkg::PORT_W-1:0] port_b_view = (port_b_data & port_b_line_dirs) |
                                            (port_b_sync & ~port_b_line_dirs);

  wire [gpio_pkg::PORT_W-1:0] ctl_view  = {xcvr_ctl, gpio_pkg::CTL_UNUSED};
  wire [gpio_pkg::PORT_W-1:0] cdir_view = {xcvr_ctl_oe, gpio_pkg::CTL_UNUSED};

  wire [gpio_pkg::PORT_W-1:0] rd_byte =
    rd_map_a_data ? port_a_view      :
    rd_map_b_data ? port_b_view      :
    rd_map_ctl    ? ctl_view         :
    rd_map_a_dir  ? port_a_line_dirs :
    rd_map_b_dir  ? port_b_line_dirs :
    rd_map_cdir   ? cdir_view        : gpio_pkg::PORT_RESET;

  wire [gpio_pkg::DATA_W-1:0] rd_word = {{(gpio_pkg::DATA_W-gpio_pkg::PORT_W){1'h0}}, rd_byte};

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign s_axi_arready = !s_axi_rvalid;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    port_a_meta <= port_a_line_in;
    port_b_meta <= port_b_line_in;
    port_a_sync <= port_a_meta;
    port_b_sync <= port_b_meta;
  end

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_hold <= 1'h0;
      aw_idx  <= '0;
    end else if (aw_take) begin
      aw_hold <= 1'h1;
      aw_idx  <= s_axi_awaddr[gpio_pkg::ADDR_W-1:gpio_pkg::BYTE_SHIFT];
    end else if (do_write) begin
      aw_hold <= 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      w_hold   <= 1'h0;
      w_data_q <= gpio_pkg::PORT_RESET;
      w_lane0  <= 1'h0;
    end else if (w_take) begin
      w_hold   <= 1'h1;
      w_data_q <= s_axi_wdata[gpio_pkg::PORT_W-1:0];
      w_lane0  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold <= 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp  <= gpio_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp  <= wr_mapped ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= gpio_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Port registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_a_data <= gpio_pkg::PORT_RESET;
      port_b_data <= gpio_pkg::PORT_RESET;
    end else begin
      if (wr_hit_a_data) port_a_data <= w_data_q;
      if (wr_hit_b_data) port_b_data <= w_data_q;
    end
  end

  // Each port has its own direction register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_a_line_dirs <= gpio_pkg::PORT_RESET;
      port_b_line_dirs <= gpio_pkg::PORT_RESET;
    end else begin
      if (wr_hit_a_dir) port_a_line_dirs <= w_data_q;
      if (wr_hit_b_dir) port_b_line_dirs <= w_data_q;
    end
  end

  // ---------------------------------------------------------------
  // Transceiver control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      xcvr_ctl    <= gpio_pkg::xcvr_ctl_s'(gpio_pkg::CTL_RESET);
      xcvr_ctl_oe <= gpio_pkg::xcvr_ctl_oe_s'(gpio_pkg::CTL_RESET);
    end else begin
      if (wr_hit_ctl)  xcvr_ctl    <= wr_ctl_bits;
      if (wr_hit_cdir) xcvr_ctl_oe <= wr_cdir_bits;
    end
  end

  // Internal layer drives the lines, external layer goes to the transceivers
  assign port_a_line_out = port_a_data;
  assign port_b_line_out = port_b_data;
  assign port_a_line_oe  = port_a_line_dirs;
  assign port_b_line_oe  = port_b_line_dirs;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  wire ctl_read_req = ar_take && (rd_map_ctl || rd_map_cdir);

  a_write_resp_bound: assert property (
    (aw_take && w_take && !s_axi_bvalid) |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");

  a_read_resp_next: assert property (
    ar_take |=> s_axi_rvalid && (s_axi_rresp == ($past(rd_mapped) ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR)))
    else $error("read response wrong or late");

  a_ctl_low_zero: assert property (
    ctl_read_req |=> s_axi_rdata[gpio_pkg::CTL_LSB-1:0] == gpio_pkg::CTL_UNUSED)
    else $error("unused control bits read nonzero");

  a_xcvr_dir_en: assert property (
    wr_hit_ctl |=> xcvr_ctl == $past(wr_ctl_bits))
    else $error("transceiver control not updated");

  a_enable_hold: assert property (
    !wr_hit_ctl |=> $stable(xcvr_ctl.port_a_xcvr_enable_n) && $stable(xcvr_ctl.port_b_xcvr_enable_n))
    else $error("transceiver enable changed without write");

  a_reset_state: assert property (
    $past(sys_rst) |-> xcvr_ctl_oe == gpio_pkg::xcvr_ctl_oe_s'(gpio_pkg::CTL_RESET) &&
                       xcvr_ctl == gpio_pkg::xcvr_ctl_s'(gpio_pkg::CTL_RESET))
    else $error("control not cleared by reset");

  a_reset_inputs: assert property (
    $past(sys_rst) |-> port_a_line_oe == gpio_pkg::PORT_RESET && port_b_line_oe == gpio_pkg::PORT_RESET &&
                       port_a_line_out == gpio_pkg::PORT_RESET && port_b_line_out == gpio_pkg::PORT_RESET)
    else $error("ports not inputs after reset");

  a_line_dir_write: assert property (
    wr_hit_a_dir |=> port_a_line_oe == $past(w_data_q) ##1 port_a_line_oe == $past(w_data_q, 2))
    else $error("port A direction not applied");

  a_ctl_oe_write: assert property (
    wr_hit_cdir |=> xcvr_ctl_oe == $past(wr_cdir_bits))
    else $error("control drive enables not updated");

  a_port_independent: assert property (
    (wr_hit_a_dir && !wr_hit_b_dir) |=> $stable(port_b_line_oe))
    else $error("port B direction disturbed");

  a_data_write: assert property (
    wr_hit_b_data |=> port_b_line_out == $past(w_data_q))
    else $error("port B data not latched");

  a_input_view: assert property (
    (ar_take && rd_map_a_data && port_a_line_dirs == gpio_pkg::PORT_RESET) |=>
      s_axi_rdata[gpio_pkg::PORT_W-1:0] == $past(port_a_sync))
    else $error("input port does not show pins");

  a_a_data_write: assert property (
    wr_hit_a_data |=> port_a_line_out == $past(w_data_q))
    else $error("port A data not latched");

  a_b_dir_write: assert property (
    wr_hit_b_dir |=> port_b_line_oe == $past(w_data_q))
    else $error("port B direction not applied");

  a_a_dir_hold: assert property (
    (wr_hit_b_dir && !wr_hit_a_dir) |=> $stable(port_a_line_oe))
    else $error("port A direction disturbed");

  a_ctl_oe_hold: assert property (
    !wr_hit_cdir |=> $stable(xcvr_ctl_oe))
    else $error("control drive enables changed without write");

  a_ctl_read_value: assert property (
    (ar_take && rd_map_ctl) |=> s_axi_rdata[gpio_pkg::PORT_W-1:gpio_pkg::CTL_LSB] == $past(xcvr_ctl))
    else $error("control read back wrong");

  a_cdir_read_value: assert property (
    (ar_take && rd_map_cdir) |=> s_axi_rdata[gpio_pkg::PORT_W-1:gpio_pkg::CTL_LSB] == $past(xcvr_ctl_oe))
    else $error("control direction read back wrong");

  a_rdata_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[gpio_pkg::DATA_W-1:gpio_pkg::PORT_W] == '0)
    else $error("read data upper bits nonzero");

  a_lane_gate: assert property (
    (do_write && !w_lane0) |=> $stable(xcvr_ctl) && $stable(xcvr_ctl_oe) &&
                               $stable(port_a_line_out) && $stable(port_b_line_out) &&
                               $stable(port_a_line_oe) && $stable(port_b_line_oe))
    else $error("write without low lane changed state");

  a_unmapped_write: assert property (
    (do_write && !wr_mapped) |=> s_axi_bvalid && s_axi_bresp == gpio_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  a_bvalid_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  c_input_read: cover property (ar_take && rd_map_a_data && port_a_line_dirs == gpio_pkg::PORT_RESET);
  c_ctl_write:  cover property (wr_hit_ctl ##[1:20] s_axi_bvalid && s_axi_bready);
  c_split_dirs: cover property (port_a_line_oe == ~gpio_pkg::PORT_RESET && port_b_line_oe == gpio_pkg::PORT_RESET);
  c_read_data:  cover property (ar_take && rd_map_a_data ##1 s_axi_rvalid);
  c_slverr:     cover property (s_axi_rvalid && s_axi_rresp == gpio_pkg::RESP_SLVERR);

endmodule : dual_port_buffered_gpio

// File: verif/xcvr_field_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// One external 8-bit transceiver with its field pins
// ---------------------------------------------------------------
module xcvr_field_model (
  input  wire logic       core_clk,
  input  wire logic       dir_ctl_oe,
  input  wire logic       en_ctl_oe,
  input  wire logic       xcvr_dir,
  input  wire logic       xcvr_enable_n,
  input  wire logic [7:0] line_out,
  input  wire logic [7:0] field_in,
  output logic      [7:0] line_in,
  output logic      [7:0] field_out,
  output logic            field_drv
);
  logic [7:0] flt;
  logic       xcvr_on;

  // Undriven control pins leave the transceiver disabled
  assign xcvr_on   = dir_ctl_oe && en_ctl_oe && !xcvr_enable_n;
  assign field_drv = xcvr_on && xcvr_dir;
  assign field_out = field_drv ? line_out : flt;
  // Port side sees a changing pattern unless the field is passed in
  assign line_in   = (xcvr_on && !xcvr_dir) ? field_in : flt;

  always @(posedge core_clk) begin
    flt <= (flt === 8'h5A) ? 8'hA5 : 8'h5A;
  end
endmodule : xcvr_field_model

// File: verif/dual_port_buffered_gpio_tb_top.sv
`timescale 1ns/1ps

module dual_port_buffered_gpio_tb_top;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [11:0] A_DAT = {gpio_pkg::IDX_PORT_A_DATA, 2'b00};
  localparam logic [11:0] B_DAT = {gpio_pkg::IDX_PORT_B_DATA, 2'b00};
  localparam logic [11:0] CTL   = {gpio_pkg::IDX_XCVR_CONTROL, 2'b00};
  localparam logic [11:0] A_DIR = {gpio_pkg::IDX_PORT_A_LINE_DIR, 2'b00};
  localparam logic [11:0] B_DIR = {gpio_pkg::IDX_PORT_B_LINE_DIR, 2'b00};
  localparam logic [11:0] C_DIR = {gpio_pkg::IDX_XCVR_CTL_DIR, 2'b00};
  logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe, fa_in, fb_in, fa_out, fb_out, da, db, v;
  logic fa_drv, fb_drv, ao;
  gpio_pkg::xcvr_ctl_s xcvr_ctl;
  gpio_pkg::xcvr_ctl_oe_s xcvr_ctl_oe;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  dual_port_buffered_gpio u_dual_port_buffered_gpio (.core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .port_a_line_in(a_in), .port_a_line_out(a_out), .port_a_line_oe(a_oe),
    .port_b_line_in(b_in), .port_b_line_out(b_out), .port_b_line_oe(b_oe), .xcvr_ctl(xcvr_ctl),
    .xcvr_ctl_oe(xcvr_ctl_oe));
  xcvr_field_model u_xcvr_field_model_a (.core_clk(core_clk), .dir_ctl_oe(xcvr_ctl_oe.port_a_xcvr_dir_ctl_oe),
    .en_ctl_oe(xcvr_ctl_oe.port_a_xcvr_en_ctl_oe), .xcvr_dir(xcvr_ctl.port_a_xcvr_dir),
    .xcvr_enable_n(xcvr_ctl.port_a_xcvr_enable_n), .line_out(a_out), .field_in(fa_in), .line_in(a_in),
    .field_out(fa_out), .field_drv(fa_drv));
  xcvr_field_model u_xcvr_field_model_b (.core_clk(core_clk), .dir_ctl_oe(xcvr_ctl_oe.port_b_xcvr_dir_ctl_oe),
    .en_ctl_oe(xcvr_ctl_oe.port_b_xcvr_en_ctl_oe), .xcvr_dir(xcvr_ctl.port_b_xcvr_dir),
    .xcvr_enable_n(xcvr_ctl.port_b_xcvr_enable_n), .line_out(b_out), .field_in(fb_in), .line_in(b_in),
    .field_out(fb_out), .field_drv(fb_drv));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  function automatic logic [31:0] cfg_rb(input logic [7:0] x);
    return {24'h0, x[7:4], 4'h0};
  endfunction : cfg_rb

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ka, kw, kb, done;
    logic [1:0] br;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= {24'($urandom()), d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge core_clk);
      ka = awready;
      kw = wready;
      kb = bvalid;
      br = bresp;
      @(posedge core_clk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      if (kb) begin
        bready <= 1'b0;
        r = br;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ka, kr, done;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge core_clk);
      ka = arready;
      kr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ka) arvalid <= 1'b0;
      if (kr) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rdr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rdr(a, rd, rsp);
    chk($sformatf("read %h", a), {rsp, rd}, {gpio_pkg::RESP_OKAY, exp});
  endtask : rchk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(71492));
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, fa_in, fb_in} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("reset pins", {a_oe, b_oe, a_out, b_out, xcvr_ctl, xcvr_ctl_oe}, '0);
    rchk(CTL, 0);
    rchk(A_DIR, 0);
    rchk(B_DIR, 0);
    rchk(C_DIR, 0);
    $display("Test reset done");
    wr(CTL, 8'h80, rsp);
    wr(A_DIR, 8'hFF, rsp);
    chk("drv undriven ctl", fa_drv, 0);
    wr(C_DIR, 8'hFF, rsp);
    rchk(C_DIR, 32'hF0);
    chk("ctl oe", xcvr_ctl_oe, 4'hF);
    chk("drv driven ctl", fa_drv, 1);
    for (int k = 0; k < 16; k++) begin
      v = {4'(k), 4'($urandom())};
      wr(CTL, v, rsp);
      chk("ctl bresp", rsp, gpio_pkg::RESP_OKAY);
      rchk(CTL, cfg_rb(v));
      chk("ctl pins", xcvr_ctl, v[7:4]);
    end
    $display("Test control done");
    for (int k = 0; k < 2; k++) begin
      ao = (k == 0);
      da = 8'($urandom());
      db = 8'($urandom());
      fa_in <= 8'($urandom());
      fb_in <= 8'($urandom());
      wr(CTL, ao ? 8'h80 : 8'h20, rsp);
      wr(A_DIR, ao ? 8'hFF : 8'h00, rsp);
      wr(B_DIR, ao ? 8'h00 : 8'hFF, rsp);
      wr(A_DAT, da, rsp);
      wr(B_DAT, db, rsp);
      chk("line oe", {a_oe, b_oe}, ao ? 16'hFF00 : 16'h00FF);
      chk("line out", {a_out, b_out}, {da, db});
      chk("field", {fa_drv, fb_drv, ao ? fa_out : fb_out}, {ao, !ao, ao ? da : db});
      rchk(A_DAT, ao ? da : fa_in);
      rchk(B_DAT, ao ? fb_in : db);
    end
    $display("Test directions done");
    wr(CTL, 8'h60, rsp);
    chk("drv disabled", {fa_drv, fb_drv}, 2'b01);
    wr(12'h000, 8'($urandom()), rsp);
    chk("unmapped bresp", rsp, gpio_pkg::RESP_SLVERR);
    rdr(12'h000, rd, rsp);
    chk("unmapped read", {rsp, rd}, {gpio_pkg::RESP_SLVERR, 32'h0});
    wstrb <= 4'hE;
    wr(CTL, 8'h10, rsp);
    wstrb <= 4'hF;
    chk("no lane bresp", rsp, gpio_pkg::RESP_OKAY);
    rchk(CTL, 32'h60);
    $display("Test unmapped done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk("rerun pins", {a_oe, b_oe, a_out, b_out, xcvr_ctl, xcvr_ctl_oe}, '0);
    rchk(CTL, 0);
    $display("Test second reset done");
    end_sim();
  end
endmodule : dual_port_buffered_gpio_tb_top
